// >>> common/pmsr_regs.svh
// Offsets, field positions, reset values and frame counts of the mode/status register
`ifndef PMSR_REGS_SVH
`define PMSR_REGS_SVH

`define PMSR_REG_ADDR 5'h19
`define PMSR_BIT_DROP 11
`define PMSR_BIT_ANEN 10
`define PMSR_BIT_FFEN 8
`define PMSR_BIT_DUP 7
`define PMSR_BIT_SPD10 6
`define PMSR_BIT_CIM 5
`define PMSR_RST_FFEN 1'h0
`define PMSR_RST_CIM 1'h0
`define PMSR_RST_DROP 1'h0
`define PMSR_PRE_LEN 6'h20
`define PMSR_HDR_LAST 5'h0D
`define PMSR_TA_LAST 5'h01
`define PMSR_DATA_LAST 5'h0F
`define PMSR_ST_CODE 2'h1
`define PMSR_OP_RD 2'h2
`define PMSR_OP_WR 2'h1

`endif

// >>> common/pmsr_pkg.sv
// Types shared by the mode/status register block
package pmsr_pkg;
    typedef logic [4:0] pmsr_addr_t;
    typedef logic [15:0] pmsr_word_t;
    typedef enum logic [1:0] {
        PMSR_PRE,
        PMSR_HDR,
        PMSR_TA,
        PMSR_DATA
    } pmsr_fsm_t;
endpackage : pmsr_pkg

// >>> common/pmsr_car_if.sv
// Carrier control signals between the register bank and the carrier logic
`timescale 1ns/1ns
interface pmsr_car_if;
    logic drop_en;
    logic speed_100;
    logic cim_clear;
    logic cim_flag;
    modport regs (output drop_en, output speed_100, output cim_clear, input cim_flag);
    modport car (input drop_en, input speed_100, input cim_clear, output cim_flag);
endinterface : pmsr_car_if

// >>> verilog/pmsr_carrier.sv
// Carrier sense gating, carrier integrity latch and first LED source mux
`timescale 1ns/1ns
`include "pmsr_regs.svh"
module pmsr_carrier (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    pmsr_car_if.car cif,
    input wire logic i_crs_raw,
    input wire logic i_desc_timeout,
    input wire logic i_desc_resync,
    input wire logic i_cim_unstable,
    input wire logic i_first_led_source_select,
    input wire logic i_first_led_output_normal,
    output logic o_crs,
    output logic o_first_led_output
);
    import pmsr_pkg::*;

    logic timed_out_r;
    logic cim_r;

    // Time-out only matters at 100 Mb/s; ends with resync or carrier loss
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timed_out_r <= 1'b0;
        end else if (cif.speed_100 && i_desc_timeout) begin
            timed_out_r <= 1'b1;
        end else if (i_desc_resync || !i_crs_raw) begin
            timed_out_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_crs <= 1'b0;
        end else begin
            o_crs <= i_crs_raw && !(timed_out_r && cif.drop_en && !i_desc_resync);
        end
    end

    // latch high, clear on read; a new event wins over the clear
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cim_r <= `PMSR_RST_CIM;
        end else if (i_cim_unstable) begin
            cim_r <= 1'b1;
        end else if (cif.cim_clear) begin
            cim_r <= 1'b0;
        end
    end

    assign cif.cim_flag = cim_r;

    // LED carries integrity status when selected
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_first_led_output <= 1'b0;
        end else begin
            o_first_led_output <= i_first_led_source_select ? cim_r : i_first_led_output_normal;
        end
    end
endmodule : pmsr_carrier

// >>> verilog/pmsr_top.sv
// Mode/status register at management address 19h with its serial management slave
`timescale 1ns/1ns
`include "pmsr_regs.svh"
module pmsr_top (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe,
    input wire pmsr_pkg::pmsr_addr_t i_phy_addr_straps,
    input wire logic i_repeater_strap,
    input wire logic i_autoneg_strap_lo,
    input wire logic i_autoneg_strap_hi,
    input wire logic i_basic_control_reg_an_enable,
    input wire logic i_basic_control_reg_full_duplex,
    input wire logic i_basic_control_reg_speed_100,
    input wire logic i_an_full_duplex,
    input wire logic i_an_speed_10,
    input wire logic i_first_led_source_select,
    input wire logic i_first_led_output_normal,
    input wire logic i_crs_raw,
    input wire logic i_desc_timeout,
    input wire logic i_desc_resync,
    input wire logic i_cim_unstable,
    output logic o_crs,
    output logic o_first_led_output,
    output logic o_far_fault_enable,
    output logic o_isolate_set
);
    import pmsr_pkg::*;

    pmsr_car_if car_if ();

    logic mdc_q_r;
    logic mdc_rise;
    pmsr_fsm_t state_r;
    logic [5:0] ones_r;
    logic [4:0] cnt_r;
    logic [12:0] hdr_r;
    logic [13:0] hdr_full;
    pmsr_word_t data_r;
    logic is_rd_r;
    logic is_wr_r;
    logic wr_commit;
    pmsr_word_t wr_word;
    logic rd_start;
    logic hdr_end;
    logic ta_end;
    logic data_end;
    logic an_active;

    logic strap_done_r;
    pmsr_addr_t phy_addr_r;
    logic drop_r;
    logic strap_an_r;
    logic ffen_r;
    logic an_en_r;
    logic dup_r;
    logic spd10_r;
    pmsr_word_t rd_word;

    // Frame header: start code, opcode, our PHY address, our register
    function automatic logic hdr_hits(input logic [13:0] hdr, input pmsr_addr_t phy,
                                      input logic [1:0] op);
        hdr_hits = (hdr[13:12] == `PMSR_ST_CODE) && (hdr[11:10] == op) &&
                   (hdr[9:5] == phy) && (hdr[4:0] == `PMSR_REG_ADDR);
    endfunction : hdr_hits

    // One more serial bit into a word, MSB first
    function automatic pmsr_word_t shift_in(input pmsr_word_t w, input logic b);
        shift_in = {w[14:0], b};
    endfunction : shift_in

    // Management clock is a plain synchronous input; act on its rising edge
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Idle clock is low, so release shows no false rise
            mdc_q_r <= 1'b0;
        end else begin
            mdc_q_r <= i_mdc;
        end
    end

    assign mdc_rise = i_mdc && !mdc_q_r;
    // Last bit of each frame field, seen at a clock rise
    assign hdr_end = mdc_rise && (state_r == PMSR_HDR) && (cnt_r == `PMSR_HDR_LAST);
    assign ta_end = mdc_rise && (state_r == PMSR_TA) && (cnt_r == `PMSR_TA_LAST);
    assign data_end = mdc_rise && (state_r == PMSR_DATA) && (cnt_r == `PMSR_DATA_LAST);
    assign hdr_full = {hdr_r, i_mdio};
    assign rd_start = hdr_end && hdr_hits(hdr_full, phy_addr_r, `PMSR_OP_RD);
    // Write commits on the rise that samples D0
    assign wr_commit = data_end && is_wr_r;
    assign wr_word = shift_in(data_r, i_mdio);
    assign an_active = i_basic_control_reg_an_enable || strap_an_r;

    // frame sequencer: preamble, header, turnaround, data
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= PMSR_PRE;
            ones_r <= 6'h00;
            cnt_r <= 5'h00;
            hdr_r <= 13'h0000;
            is_rd_r <= 1'b0;
            is_wr_r <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state_r)
                PMSR_PRE: begin
                    if (i_mdio) begin
                        // Saturating count; longer preambles are legal
                        if (ones_r != `PMSR_PRE_LEN) begin
                            ones_r <= ones_r + 6'h01;
                        end
                    end else if (ones_r == `PMSR_PRE_LEN) begin
                        state_r <= PMSR_HDR;
                        hdr_r <= 13'h0000;
                        cnt_r <= 5'h01;
                        ones_r <= 6'h00;
                    end else begin
                        ones_r <= 6'h00;
                    end
                end
                PMSR_HDR: begin
                    hdr_r <= hdr_full[12:0];
                    if (cnt_r == `PMSR_HDR_LAST) begin
                        is_rd_r <= hdr_hits(hdr_full, phy_addr_r, `PMSR_OP_RD);
                        is_wr_r <= hdr_hits(hdr_full, phy_addr_r, `PMSR_OP_WR);
                        // Frames for others are skipped; data cannot mimic a preamble
                        state_r <= PMSR_TA;
                        cnt_r <= 5'h00;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                PMSR_TA: begin
                    if (cnt_r == `PMSR_TA_LAST) begin
                        state_r <= PMSR_DATA;
                        cnt_r <= 5'h00;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                PMSR_DATA: begin
                    if (cnt_r == `PMSR_DATA_LAST) begin
                        state_r <= PMSR_PRE;
                        is_rd_r <= 1'b0;
                        is_wr_r <= 1'b0;
                        cnt_r <= 5'h00;
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
            endcase
        end
    end

    // Read word snapped at header end, shifted out; write word shifted in
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_r <= 16'h0000;
        end else if (rd_start) begin
            data_r <= rd_word;
        end else if (mdc_rise && (state_r == PMSR_DATA)) begin
            data_r <= shift_in(data_r, i_mdio);
        end else if (ta_end && is_rd_r) begin
            // D15 leaves on this rise; line up D14
            data_r <= shift_in(data_r, 1'b0);
        end
    end

    // Drive zero for second turnaround bit, then D15..D0, then release
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mdio <= 1'b0;
            o_mdio_oe <= 1'b0;
        end else if (mdc_rise && is_rd_r) begin
            if (state_r == PMSR_TA) begin
                o_mdio_oe <= 1'b1;
                o_mdio <= (cnt_r == `PMSR_TA_LAST) ? data_r[15] : 1'b0;
            end else if (state_r == PMSR_DATA) begin
                // Let go on the rise that samples D0
                o_mdio_oe <= (cnt_r != `PMSR_DATA_LAST);
                o_mdio <= (cnt_r != `PMSR_DATA_LAST) ? data_r[15] : 1'b0;
            end
        end
    end

    // Straps caught on the first edge after reset release
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_done_r <= 1'b0;
            phy_addr_r <= 5'h00;
            strap_an_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            // Taken once; later pin changes are ignored
            // latch address straps
            phy_addr_r <= i_phy_addr_straps;
            strap_an_r <= i_autoneg_strap_lo && i_autoneg_strap_hi;
        end
    end

    // default is the inverse of the repeater strap
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drop_r <= `PMSR_RST_DROP;
        end else if (!strap_done_r) begin
            drop_r <= !i_repeater_strap;
        end else if (wr_commit) begin
            // Software may override the strap default
            drop_r <= wr_word[`PMSR_BIT_DROP];
        end
    end

    // far-end fault enable, written by software
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ffen_r <= `PMSR_RST_FFEN;
        end else if (wr_commit) begin
            ffen_r <= wr_word[`PMSR_BIT_FFEN];
        end
    end

    // Live status sampled each cycle; negotiated values when negotiation is on
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            an_en_r <= 1'b0;
            dup_r <= 1'b0;
            spd10_r <= 1'b0;
        end else begin
            an_en_r <= an_active;
            // Negotiated values may be stale until negotiation completes
            // one means full duplex
            dup_r <= an_active ? i_an_full_duplex : i_basic_control_reg_full_duplex;
            spd10_r <= an_active ? i_an_speed_10 : !i_basic_control_reg_speed_100;
        end
    end

    always_comb begin
        rd_word = 16'h0000;
        rd_word[`PMSR_BIT_DROP] = drop_r;
        rd_word[`PMSR_BIT_ANEN] = an_en_r;
        rd_word[`PMSR_BIT_FFEN] = ffen_r;
        rd_word[`PMSR_BIT_DUP] = dup_r;
        rd_word[`PMSR_BIT_SPD10] = spd10_r;
        rd_word[`PMSR_BIT_CIM] = car_if.cim_flag;
        rd_word[4:0] = phy_addr_r;
    end

    assign car_if.drop_en = drop_r;
    assign car_if.speed_100 = !spd10_r;
    // the read snapshot clears the flag
    assign car_if.cim_clear = rd_start;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_far_fault_enable <= `PMSR_RST_FFEN;
            o_isolate_set <= 1'b0;
        end else begin
            // registered copy for the fault logic
            o_far_fault_enable <= ffen_r;
            o_isolate_set <= strap_done_r && (phy_addr_r == 5'h00);
        end
    end

    pmsr_carrier u_carrier (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .cif(car_if),
        .i_crs_raw(i_crs_raw),
        .i_desc_timeout(i_desc_timeout),
        .i_desc_resync(i_desc_resync),
        .i_cim_unstable(i_cim_unstable),
        .i_first_led_source_select(i_first_led_source_select),
        .i_first_led_output_normal(i_first_led_output_normal),
        .o_crs(o_crs),
        .o_first_led_output(o_first_led_output)
    );
endmodule : pmsr_top

// >>> verif/pmsr_checker.sv
// Port-level assertions for the mode/status register block
`timescale 1ns/1ns
module pmsr_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire pmsr_pkg::pmsr_addr_t i_phy_addr_straps,
    input wire logic i_first_led_source_select,
    input wire logic i_first_led_output_normal,
    input wire logic i_crs_raw,
    input wire logic i_desc_resync,
    input wire logic i_cim_unstable,
    input wire logic o_mdio,
    input wire logic o_mdio_oe,
    input wire logic o_crs,
    input wire logic o_first_led_output,
    input wire logic o_far_fault_enable,
    input wire logic o_isolate_set
);
    import pmsr_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence read_start;
        $rose(o_mdio_oe);
    endsequence
    sequence unstable_seen;
        i_first_led_source_select && i_cim_unstable ##1 i_first_led_source_select;
    endsequence
    AST_TA_ZERO: assert property (read_start |-> !o_mdio)
        else $error("turnaround bit not low");
    // Seventeen clock rises of at least two cycles each follow
    AST_OE_HELD: assert property (read_start |=> o_mdio_oe [*8])
        else $error("read drive released early");
    AST_RD_NO_WRITE: assert property (o_mdio_oe |-> $stable(o_far_fault_enable))
        else $error("read changed far fault enable");
    AST_FF_RESET: assert property ($rose(i_rst_n) |-> !o_far_fault_enable)
        else $error("far fault enable not clear after reset");
    AST_LED_NORMAL: assert property (!i_first_led_source_select
        |=> o_first_led_output == $past(i_first_led_output_normal))
        else $error("led not on its normal source");
    AST_LED_FLAG: assert property (unstable_seen |-> ##[0:1] o_first_led_output)
        else $error("led missed integrity flag");
    AST_CRS_NO_RAW: assert property (!i_crs_raw |=> !o_crs)
        else $error("carrier sense without raw carrier");
    AST_CRS_RESYNC: assert property (i_crs_raw && i_desc_resync |=> o_crs)
        else $error("carrier sense low after resync");
    AST_ISO_ZERO: assert property ($rose(o_isolate_set) |-> i_phy_addr_straps == 5'h00)
        else $error("isolate raised for nonzero address");
    AST_ISO_STEADY: assert property ($past(i_rst_n) && $past(i_rst_n, 2) && $past(i_rst_n, 3)
        |-> $stable(o_isolate_set))
        else $error("isolate moved after straps latched");
endmodule : pmsr_checker

bind pmsr_top pmsr_checker u_pmsr_checker (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_phy_addr_straps(i_phy_addr_straps),
    .i_first_led_source_select(i_first_led_source_select), .i_first_led_output_normal(i_first_led_output_normal),
    .i_crs_raw(i_crs_raw), .i_desc_resync(i_desc_resync), .i_cim_unstable(i_cim_unstable),
    .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe), .o_crs(o_crs),
    .o_first_led_output(o_first_led_output), .o_far_fault_enable(o_far_fault_enable),
    .o_isolate_set(o_isolate_set)
);

// >>> verif/pmsr_sme.sv
// Station management master model for the serial management frames
`timescale 1ns/1ns
`include "pmsr_regs.svh"
module pmsr_sme (
    input wire logic i_clk_sys,
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio,
    output logic o_mdio_oe,
    output logic o_rd_valid,
    output pmsr_pkg::pmsr_word_t o_rd_word
);
    import pmsr_pkg::*;
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_word = '0;
    end
    // Data moves only while the clock is low; sampled just after the slave updates
    task automatic bit_cyc(input logic b, input logic drv, output logic s);
        @(posedge i_clk_sys);
        o_mdc <= 1'b0;
        o_mdio <= b;
        o_mdio_oe <= drv;
        repeat (2) @(posedge i_clk_sys);
        o_mdc <= 1'b1;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        s = i_mdio;
    endtask : bit_cyc
    task automatic frame(input logic [1:0] op, input pmsr_addr_t pa, input pmsr_addr_t ra,
                         input pmsr_word_t wd);
        logic [63:0] f;
        logic s;
        pmsr_word_t rd;
        f = {32'hFFFFFFFF, `PMSR_ST_CODE, op, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            bit_cyc(f[i], (i > 17) || (op == `PMSR_OP_WR), s);
            // Driven on a rise, read just after that same rise: the last sample is spare
            if (i > 0) begin
                rd = {rd[14:0], s};
            end
        end
        // Clock stands still and the line is released between frames
        @(posedge i_clk_sys);
        o_mdc <= 1'b0;
        o_mdio_oe <= 1'b0;
        o_rd_word <= rd;
        o_rd_valid <= (op == `PMSR_OP_RD);
        @(posedge i_clk_sys);
        o_rd_valid <= 1'b0;
    endtask : frame
endmodule : pmsr_sme

// >>> verif/pmsr_bench.sv
// Self-checking bench for the mode/status register block
`timescale 1ns/1ns
`include "pmsr_regs.svh"
module pmsr_bench;
    import pmsr_pkg::*;
    logic i_clk_sys, i_rst_n, mdc, sme_mdio, sme_oe, mdio_o, mdio_oe, rd_valid;
    logic rep, an_lo, an_hi, bm_an, bm_fd, bm_s100, an_fd, an_s10, sel, led_norm;
    logic crs_raw, d_to, d_rs, unst, crs, led, ffen, iso;
    wire logic mdio_w;
    pmsr_addr_t straps;
    pmsr_word_t rd_word;
    pmsr_word_t exp_q[$];
    logic [7:0] rnd = 8'h45;
    int fails = 0;
    int cmp_count = 0;
    // Pull-up holds the line when nobody drives
    assign mdio_w = mdio_oe ? mdio_o : (sme_oe ? sme_mdio : 1'b1);
    pmsr_top DUT (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_mdc(mdc), .i_mdio(mdio_w),
        .o_mdio(mdio_o), .o_mdio_oe(mdio_oe), .i_phy_addr_straps(straps),
        .i_repeater_strap(rep), .i_autoneg_strap_lo(an_lo), .i_autoneg_strap_hi(an_hi),
        .i_basic_control_reg_an_enable(bm_an), .i_basic_control_reg_full_duplex(bm_fd), .i_basic_control_reg_speed_100(bm_s100),
        .i_an_full_duplex(an_fd), .i_an_speed_10(an_s10), .i_first_led_source_select(sel),
        .i_first_led_output_normal(led_norm), .i_crs_raw(crs_raw), .i_desc_timeout(d_to),
        .i_desc_resync(d_rs), .i_cim_unstable(unst), .o_crs(crs),
        .o_first_led_output(led), .o_far_fault_enable(ffen), .o_isolate_set(iso)
    );
    pmsr_sme u_sme (
        .i_clk_sys(i_clk_sys), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(sme_mdio),
        .o_mdio_oe(sme_oe), .o_rd_valid(rd_valid), .o_rd_word(rd_word)
    );
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic check(input string what, input pmsr_word_t exp, input pmsr_word_t seen);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic pmsr_word_t exp_word(input logic drop, input logic ff, input logic integ);
        logic an;
        an = bm_an | (an_lo & an_hi);
        return {4'h0, drop, an, 1'b0, ff, an ? an_fd : bm_fd, an ? an_s10 : ~bm_s100, integ, straps};
    endfunction : exp_word
    task automatic rd_exp(input pmsr_word_t e);
        exp_q.push_back(e);
        u_sme.frame(`PMSR_OP_RD, straps, `PMSR_REG_ADDR, 16'h0000);
    endtask : rd_exp
    task automatic wr(input pmsr_addr_t pa, input pmsr_addr_t ra, input pmsr_word_t d);
        u_sme.frame(`PMSR_OP_WR, pa, ra, d);
    endtask : wr
    task automatic do_reset(input pmsr_addr_t a);
        i_rst_n <= 1'b0;
        straps <= a;
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
    endtask : do_reset
    task automatic timeout_check(input logic e);
        d_to <= 1'b1;
        @(posedge i_clk_sys);
        d_to <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        check("crs after timeout", e, crs);
    endtask : timeout_check
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge i_clk_sys) begin
        if (rd_valid === 1'b1) begin
            check("read word", exp_q.size() ? exp_q.pop_front() : 16'hXXXX, rd_word);
        end
    end
    initial begin
        {i_rst_n, rep, an_lo, an_hi, bm_an, bm_fd, bm_s100, an_fd, an_s10} = '0;
        {sel, led_norm, crs_raw, d_to, d_rs, unst} = '0;
        straps = 5'h00;
        @(posedge i_clk_sys);
        rnd = lfsr(rnd);
        rep <= rnd[0];
        do_reset(rnd[7:3] | 5'h01);
        check("isolate", 1'b0, iso);
        rd_exp(exp_word(~rep, 1'b0, 1'b0));
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            {bm_an, bm_fd, bm_s100, an_fd, an_s10} <= rnd[4:0];
            @(posedge i_clk_sys);
            // negotiation on or off at random; inputs settled a cycle before reading
            rd_exp(exp_word(~rep, 1'b0, 1'b0));
        end
        // only two bits take a write; foreign frames refused
        wr(straps, `PMSR_REG_ADDR, 16'hFFFF);
        check("far fault", 1'b1, ffen);
        wr(straps, 5'h18, 16'h0000);
        wr(~straps, `PMSR_REG_ADDR, 16'h0000);
        exp_q.push_back(16'hFFFF);
        u_sme.frame(`PMSR_OP_RD, ~straps, `PMSR_REG_ADDR, 16'h0000);
        rd_exp(exp_word(1'b1, 1'b1, 1'b0));
        bm_an <= 1'b0;
        bm_s100 <= 1'b1;
        crs_raw <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        check("crs on", 1'b1, crs);
        timeout_check(1'b0);
        d_rs <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        check("crs resync", 1'b1, crs);
        d_rs <= 1'b0;
        wr(straps, `PMSR_REG_ADDR, 16'h0000);
        check("far fault", 1'b0, ffen);
        timeout_check(1'b1);
        // flag latches, shows on the LED, clears on read
        led_norm <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        check("led normal", 1'b1, led);
        sel <= 1'b1;
        unst <= 1'b1;
        @(posedge i_clk_sys);
        unst <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        check("led flag", 1'b1, led);
        rd_exp(exp_word(1'b0, 1'b0, 1'b1));
        rd_exp(exp_word(1'b0, 1'b0, 1'b0));
        check("led cleared", 1'b0, led);
        an_lo <= 1'b1;
        an_hi <= 1'b1;
        do_reset(5'h00);
        check("isolate", 1'b1, iso);
        rd_exp(exp_word(~rep, 1'b0, 1'b0));
        repeat (4) @(posedge i_clk_sys);
        tally_and_finish();
    end
    initial begin
        // Sixteen frames of about 260 cycles each, with ample margin
        repeat (20000) @(posedge i_clk_sys);
        fails++;
        tally_and_finish();
    end
endmodule : pmsr_bench
